// file: inc/can_mode_pkg.sv
// Purpose: Constants shared by the CAN mode and transmit-buffer block.
// Assumes: 16-bit registers on a small word-addressed register port.
// Notes: Mode codes for the unsupported modes are not listed here.
package can_mode_pkg;

// ****************************************
// Register map
// ****************************************
localparam logic [2:0] ADDR_MODE = 3'h0;
localparam logic [2:0] ADDR_FILT = 3'h1;
localparam logic [2:0] ADDR_TXCTL = 3'h2;
localparam logic [2:0] ADDR_ISTAT = 3'h3;
localparam logic [2:0] ADDR_IMASK = 3'h4;
localparam logic [2:0] ADDR_ERRCNT = 3'h5;
localparam logic [15:0] FILT_RESET = 16'h0000;
localparam logic [7:0] TXCTL_RESET = 8'h00;

// ****************************************
// Mode fields and states
// ****************************************
localparam int REQ_LSB = 8;
localparam int READBACK_LSB = 5;
localparam logic [2:0] REQ_NORMAL = 3'h0;
localparam logic [2:0] REQ_LOOPBACK = 3'h2;
localparam logic [2:0] REQ_LISTEN_ONLY = 3'h3;
localparam logic [2:0] REQ_LISTEN_ALL = 3'h7;
typedef enum logic [3:0] {
    MODE_NORMAL = 4'b0001,
    MODE_LOOPBACK = 4'b0010,
    MODE_LISTEN_ONLY = 4'b0100,
    MODE_LISTEN_ALL = 4'b1000
} mode_e;
localparam logic [3:0] IDLE_BITS = 4'hb;

// ****************************************
// Transmit buffer byte and filter pointer fields
// ****************************************
localparam int NUM_TXBUF = 2;
localparam int BUF_BITS = 8;
localparam int DIR_BIT = 7;
localparam int ABT_BIT = 6;
localparam int LARB_BIT = 5;
localparam int ERR_BIT = 4;
localparam int REQ_BIT = 3;
localparam int RTR_BIT = 2;
localparam int PRI_LSB = 0;
localparam int DEST_BITS = 4;
localparam logic [3:0] FIFO_CODE = 4'hf;

// ****************************************
// Interrupt bits and error counter steps
// ****************************************
localparam int IRQ_W = 4;
localparam int IRQ_MODE = 0;
localparam int IRQ_TXOK = 1;
localparam int IRQ_TXERR = 2;
localparam int IRQ_RXPART = 3;
localparam logic [7:0] TX_ERR_STEP = 8'h08;
localparam logic [7:0] RX_ERR_STEP = 8'h01;
localparam logic [7:0] CNT_MAX = 8'hff;

endpackage

// file: src/can_mode_tx_ctrl.sv
// Purpose: Operating modes, transmit buffer control and filter routing.
// Assumes: A protocol engine beside it supplies bit ticks and events.
// Notes: Register read data appears the cycle after the read strobe.
module can_mode_tx_ctrl (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic bit_tick,
    input wire logic engine_tx,
    input wire logic [1:0] tx_ok,
    input wire logic [1:0] tx_err,
    input wire logic [1:0] tx_lost,
    input wire logic [1:0] abort_ack,
    input wire logic [1:0] remote_match,
    input wire logic rx_ok,
    input wire logic rx_err,
    input wire logic hit_valid,
    input wire logic [1:0] hit_filter,
    input wire logic bus_receive_pin,
    output logic bus_transmit_pin_out,
    output logic bus_transmit_pin_oe,
    output logic engine_rx,
    output logic ack_enable,
    output logic error_flag_enable,
    output logic accept_all,
    output logic partial_copy,
    output logic tx_pending,
    output logic tx_index,
    output logic [1:0] abort_req,
    output logic dest_valid,
    output logic dest_fifo,
    output logic [3:0] dest_buffer,
    output logic irq
);

// ****************************************
// Declarations
// ****************************************
localparam int IRQ_W_L = can_mode_pkg::IRQ_W;
can_mode_pkg::mode_e mode_reg;
can_mode_pkg::mode_e mode_next;
logic [2:0] req_field_reg;
logic [2:0] readback;
logic [3:0] idle_cnt_reg;
logic idle;
logic rx_now;
logic [15:0] filt_reg;
logic [1:0] dir_v;
logic [1:0] req_v;
logic [1:0] pri_v [2];
logic [15:0] txctl_v;
logic [IRQ_W_L-1:0] istat_reg;
logic [IRQ_W_L-1:0] imask_reg;
logic [IRQ_W_L-1:0] ev;
logic [7:0] tec_reg;
logic [7:0] rec_reg;
logic cnt_en;
logic txctl_wr;
logic sel_valid;
logic sel_idx;
logic [3:0] dest_code;

// ****************************************
// Mode control
// ****************************************
// Decodes the requested code; unsupported codes keep the present mode.
always_comb
begin
    mode_next = mode_reg;
    case (req_field_reg)
        can_mode_pkg::REQ_NORMAL: mode_next = can_mode_pkg::MODE_NORMAL;
        can_mode_pkg::REQ_LOOPBACK: mode_next = can_mode_pkg::MODE_LOOPBACK;
        can_mode_pkg::REQ_LISTEN_ONLY: mode_next = can_mode_pkg::MODE_LISTEN_ONLY;
        can_mode_pkg::REQ_LISTEN_ALL: mode_next = can_mode_pkg::MODE_LISTEN_ALL;
        default: mode_next = mode_reg;
    endcase
end

// Encodes the entered mode for the read-back field.
always_comb
begin
    case (mode_reg)
        can_mode_pkg::MODE_NORMAL: readback = can_mode_pkg::REQ_NORMAL;
        can_mode_pkg::MODE_LOOPBACK: readback = can_mode_pkg::REQ_LOOPBACK;
        can_mode_pkg::MODE_LISTEN_ONLY: readback = can_mode_pkg::REQ_LISTEN_ONLY;
        can_mode_pkg::MODE_LISTEN_ALL: readback = can_mode_pkg::REQ_LISTEN_ALL;
        default: readback = can_mode_pkg::REQ_NORMAL;
    endcase
end

// The level the engine samples; loopback takes its own transmit level.
assign rx_now = (mode_reg == can_mode_pkg::MODE_LOOPBACK) ? engine_tx : bus_receive_pin;
assign idle = (idle_cnt_reg == can_mode_pkg::IDLE_BITS);

// Counts consecutive recessive bits, saturating at the idle figure.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
        idle_cnt_reg <= 4'h0;
    else if (bit_tick)
    begin
        if (!rx_now)
            idle_cnt_reg <= 4'h0;
        else if (!idle)
            idle_cnt_reg <= idle_cnt_reg + 4'h1;
    end
end

// Holds the request and moves to the new mode only on an idle bus.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        req_field_reg <= can_mode_pkg::REQ_NORMAL;
        mode_reg <= can_mode_pkg::MODE_NORMAL;
    end
    else
    begin
        if (reg_wr && reg_addr == can_mode_pkg::ADDR_MODE)
            req_field_reg <= reg_wdata[can_mode_pkg::REQ_LSB +: 3];
        if (idle)
            mode_reg <= mode_next;
    end
end

// ****************************************
// Pins and engine controls
// ****************************************
// Normal mode drives the pin; listen-only and loopback release it.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        bus_transmit_pin_out <= 1'b1;
        bus_transmit_pin_oe <= 1'b0;
        engine_rx <= 1'b1;
        ack_enable <= 1'b0;
        error_flag_enable <= 1'b0;
        accept_all <= 1'b0;
        partial_copy <= 1'b0;
    end
    else
    begin
        bus_transmit_pin_out <= engine_tx;
        bus_transmit_pin_oe <= (mode_reg == can_mode_pkg::MODE_NORMAL) ||
            (mode_reg == can_mode_pkg::MODE_LISTEN_ALL);
        engine_rx <= rx_now;
        ack_enable <= (mode_reg == can_mode_pkg::MODE_NORMAL) ||
            (mode_reg == can_mode_pkg::MODE_LOOPBACK);
        error_flag_enable <= (mode_reg == can_mode_pkg::MODE_NORMAL) ||
            (mode_reg == can_mode_pkg::MODE_LOOPBACK);
        accept_all <= (mode_reg == can_mode_pkg::MODE_LISTEN_ALL);
        partial_copy <= rx_err && (mode_reg == can_mode_pkg::MODE_LISTEN_ALL);
    end
end

// ****************************************
// Error counters
// ****************************************
assign cnt_en = (mode_reg == can_mode_pkg::MODE_NORMAL) ||
    (mode_reg == can_mode_pkg::MODE_LOOPBACK);

// Counts errors up and good frames down, only while errors are honoured.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        tec_reg <= 8'h00;
        rec_reg <= 8'h00;
    end
    else if (cnt_en)
    begin
        if (|tx_err)
            tec_reg <= (tec_reg > can_mode_pkg::CNT_MAX - can_mode_pkg::TX_ERR_STEP) ?
                can_mode_pkg::CNT_MAX : tec_reg + can_mode_pkg::TX_ERR_STEP;
        else if (|tx_ok && tec_reg != 8'h00)
            tec_reg <= tec_reg - 8'h01;
        if (rx_err && rec_reg != can_mode_pkg::CNT_MAX)
            rec_reg <= rec_reg + can_mode_pkg::RX_ERR_STEP;
        else if (rx_ok && !rx_err && rec_reg != 8'h00)
            rec_reg <= rec_reg - 8'h01;
    end
end

// ****************************************
// Filter pointer routing
// ****************************************
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
        filt_reg <= can_mode_pkg::FILT_RESET;
    else if (reg_wr && reg_addr == can_mode_pkg::ADDR_FILT)
        filt_reg <= reg_wdata;
end

// Filter 4 sits in the low nibble, filter 7 in the high one.
assign dest_code = filt_reg[hit_filter * can_mode_pkg::DEST_BITS +: 4];

// Presents the destination of each filter hit for one cycle.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        dest_valid <= 1'b0;
        dest_fifo <= 1'b0;
        dest_buffer <= 4'h0;
    end
    else
    begin
        dest_valid <= hit_valid;
        dest_fifo <= hit_valid && dest_code == can_mode_pkg::FIFO_CODE;
        dest_buffer <= dest_code;
    end
end

// ****************************************
// Transmit buffers
// ****************************************
assign txctl_wr = reg_wr && reg_addr == can_mode_pkg::ADDR_TXCTL;

generate
    for (genvar b = 0; b < can_mode_pkg::NUM_TXBUF; b++)
    begin : buf_g
        logic dir_reg;
        logic abt_reg;
        logic larb_reg;
        logic err_reg;
        logic req_reg;
        logic rtr_reg;
        logic [1:0] pri_reg;
        logic abo_reg;
        logic [7:0] wb;
        assign wb = reg_wdata[b * can_mode_pkg::BUF_BITS +: 8];

        // Writable settings of the buffer.
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                dir_reg <= can_mode_pkg::TXCTL_RESET[can_mode_pkg::DIR_BIT];
                rtr_reg <= can_mode_pkg::TXCTL_RESET[can_mode_pkg::RTR_BIT];
                pri_reg <= can_mode_pkg::TXCTL_RESET[can_mode_pkg::PRI_LSB +: 2];
            end
            else if (txctl_wr)
            begin
                dir_reg <= wb[can_mode_pkg::DIR_BIT];
                rtr_reg <= wb[can_mode_pkg::RTR_BIT];
                pri_reg <= wb[can_mode_pkg::PRI_LSB +: 2];
            end
        end

        // Send request: clears on success or abort, any set wins.
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
                req_reg <= 1'b0;
            else if ((txctl_wr && wb[can_mode_pkg::REQ_BIT]) ||
                     (remote_match[b] && rtr_reg))
                req_reg <= 1'b1;
            else if (tx_ok[b] || abort_ack[b])
                req_reg <= 1'b0;
        end

        // Abort request: a zero written over a set request asks to abort.
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
                abo_reg <= 1'b0;
            else if (txctl_wr && !wb[can_mode_pkg::REQ_BIT] && req_reg)
                abo_reg <= 1'b1;
            else if (tx_ok[b] || abort_ack[b] || !req_reg)
                abo_reg <= 1'b0;
        end

        // Outcome flags of the last attempt; a new event wins over clears.
        always_ff @(posedge ref_clk or negedge reset_n)
        begin
            if (!reset_n)
            begin
                err_reg <= 1'b0;
                larb_reg <= 1'b0;
                abt_reg <= 1'b0;
            end
            else
            begin
                if (tx_err[b])
                    err_reg <= 1'b1;
                else if (tx_ok[b])
                    err_reg <= 1'b0;
                if (tx_lost[b])
                    larb_reg <= 1'b1;
                else if (tx_ok[b])
                    larb_reg <= 1'b0;
                if (abort_ack[b])
                    abt_reg <= 1'b1;
                else if (txctl_wr && wb[can_mode_pkg::REQ_BIT])
                    abt_reg <= 1'b0;
            end
        end

        assign txctl_v[b * can_mode_pkg::BUF_BITS +: 8] =
            {dir_reg, abt_reg, larb_reg, err_reg, req_reg, rtr_reg, pri_reg};
        assign dir_v[b] = dir_reg;
        assign req_v[b] = req_reg;
        assign pri_v[b] = pri_reg;
        assign abort_req[b] = abo_reg;
    end
endgenerate

// Picks the pending transmit buffer of highest priority; buffer 1 wins ties.
always_comb
begin
    sel_valid = cnt_en && |(req_v & dir_v);
    sel_idx = 1'b0;
    if (req_v[1] && dir_v[1] && (!(req_v[0] && dir_v[0]) || pri_v[1] >= pri_v[0]))
        sel_idx = 1'b1;
end

// Registers the selection handed to the engine.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        tx_pending <= 1'b0;
        tx_index <= 1'b0;
    end
    else
    begin
        tx_pending <= sel_valid;
        tx_index <= sel_idx;
    end
end

// ****************************************
// Interrupts
// ****************************************
assign ev[can_mode_pkg::IRQ_MODE] = idle && mode_next != mode_reg;
assign ev[can_mode_pkg::IRQ_TXOK] = |tx_ok;
assign ev[can_mode_pkg::IRQ_TXERR] = |tx_err;
assign ev[can_mode_pkg::IRQ_RXPART] = rx_err && mode_reg == can_mode_pkg::MODE_LISTEN_ALL;

// Sticky status cleared by writing ones; a new event wins over the clear.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        istat_reg <= '0;
        imask_reg <= '0;
        irq <= 1'b0;
    end
    else
    begin
        if (reg_wr && reg_addr == can_mode_pkg::ADDR_ISTAT)
            istat_reg <= (istat_reg & ~reg_wdata[IRQ_W_L-1:0]) | ev;
        else
            istat_reg <= istat_reg | ev;
        if (reg_wr && reg_addr == can_mode_pkg::ADDR_IMASK)
            imask_reg <= reg_wdata[IRQ_W_L-1:0];
        irq <= |(istat_reg & imask_reg);
    end
end

// ****************************************
// Register read port
// ****************************************
// Read data stands one cycle after the strobe; unmapped reads give zero.
always_ff @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
        reg_rdata <= 16'h0000;
    else if (!reg_rd)
        reg_rdata <= 16'h0000;
    else
        case (reg_addr)
            can_mode_pkg::ADDR_MODE: reg_rdata <= {5'h00, req_field_reg, readback, 5'h00};
            can_mode_pkg::ADDR_FILT: reg_rdata <= filt_reg;
            can_mode_pkg::ADDR_TXCTL: reg_rdata <= txctl_v;
            can_mode_pkg::ADDR_ISTAT: reg_rdata <= {12'h000, istat_reg};
            can_mode_pkg::ADDR_IMASK: reg_rdata <= {12'h000, imask_reg};
            can_mode_pkg::ADDR_ERRCNT: reg_rdata <= {tec_reg, rec_reg};
            default: reg_rdata <= 16'h0000;
        endcase
end

// ****************************************
// Assertions
// ****************************************
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!reset_n);

sequence abort_write_s;
    txctl_wr && !reg_wdata[can_mode_pkg::REQ_BIT] && buf_g[0].req_reg;
endsequence
sequence clean_ok_s;
    tx_ok[0] && !txctl_wr && !remote_match[0];
endsequence

a_mode_waits_idle: assert property ($changed(mode_reg) |-> $past(idle))
    else $error("mode changed without an idle bus");
a_listen_passive: assert property (mode_reg == can_mode_pkg::MODE_LISTEN_ONLY
    |=> !ack_enable && !error_flag_enable)
    else $error("listen-only mode not passive");
a_counter_frozen: assert property (mode_reg == can_mode_pkg::MODE_LISTEN_ONLY
    |=> $stable(tec_reg) && $stable(rec_reg))
    else $error("error counter moved in listen-only mode");
a_pin_released: assert property ((mode_reg == can_mode_pkg::MODE_LISTEN_ONLY ||
    mode_reg == can_mode_pkg::MODE_LOOPBACK) |=> !bus_transmit_pin_oe)
    else $error("transmit pin driven while released");
a_loop_route: assert property (mode_reg == can_mode_pkg::MODE_LOOPBACK
    |=> engine_rx == $past(engine_tx))
    else $error("loopback does not return transmit level");
a_normal_drive: assert property (reset_n && mode_reg == can_mode_pkg::MODE_NORMAL
    |=> bus_transmit_pin_oe && bus_transmit_pin_out == $past(engine_tx))
    else $error("normal mode does not drive the pin");
a_partial_copy: assert property (rx_err && mode_reg == can_mode_pkg::MODE_LISTEN_ALL
    |=> partial_copy ##1 (!partial_copy || $past(rx_err)))
    else $error("partial message not copied");
a_fifo_route: assert property (hit_valid && dest_code == can_mode_pkg::FIFO_CODE
    |=> dest_valid && dest_fifo)
    else $error("fifo code not routed to fifo");
a_filter_field: assert property (hit_valid && hit_filter == 2'h3
    |=> dest_buffer == $past(filt_reg[15:12]))
    else $error("filter seven field misplaced");
a_req_clears: assert property (clean_ok_s |=> !buf_g[0].req_reg)
    else $error("send request not cleared after success");
a_abort_request: assert property (abort_write_s |=> abort_req[0])
    else $error("abort not requested");
a_remote_sets: assert property (remote_match[0] && buf_g[0].rtr_reg
    |=> buf_g[0].req_reg)
    else $error("remote frame did not set send request");
a_error_flag: assert property (tx_err[0] |=> buf_g[0].err_reg ##1
    (buf_g[0].err_reg || $past(tx_ok[0])))
    else $error("send error flag not held");
a_prio_pick: assert property (sel_valid && &(req_v & dir_v) && pri_v[0] > pri_v[1]
    |=> tx_pending && !tx_index)
    else $error("lower priority buffer chosen");

endmodule // can_mode_tx_ctrl

// file: tb/can_bus_model.sv
// Purpose: Far-side model of the bus: bit sample ticks and a wired bus level.
// Assumes: Recessive is 1 and the bus is pulled recessive when nobody drives.
// Notes: Another node may hold the bus dominant when the bench asks for it.
module can_bus_model (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic tx_out,
    input wire logic tx_oe,
    input wire logic dominant,
    output logic bit_tick,
    output logic rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg;

    // One bit time lasts four clocks, so idle detection stays short.
    always_ff @(posedge ref_clk or negedge reset_n)
        if (!reset_n)
            div_reg <= 2'h0;
        else
            div_reg <= div_reg + 2'h1;
    assign bit_tick = (div_reg == 2'h3);
    // Wired-AND with pull-up: a released pin reads recessive.
    assign rx_pin = !dominant && (!tx_oe || tx_out);
endmodule // can_bus_model

// file: tb/can_modes_tx_buffer_control_tb_top.sv
// Purpose: Self-checking bench for the CAN mode and transmit buffer block.
// Assumes: The bus model ticks one bit every four clocks.
// Notes: Read data is sampled in the cycle after the read strobe only.
module can_modes_tx_buffer_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset_n, reg_wr, reg_rd, bit_tick, engine_tx, rx_ok, rx_err, hit_valid;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic [1:0] tx_ok, tx_err, tx_lost, abort_ack, remote_match, hit_filter, abort_req;
    logic bus_receive_pin, bus_transmit_pin_out, bus_transmit_pin_oe, engine_rx, dominant;
    logic ack_enable, error_flag_enable, accept_all, partial_copy, tx_pending, tx_index;
    logic dest_valid, dest_fifo, irq;
    logic [3:0] dest_buffer;
    int fails, checks, cyc;

    can_mode_tx_ctrl i_dut (.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .bit_tick, .engine_tx, .tx_ok, .tx_err, .tx_lost, .abort_ack,
        .remote_match, .rx_ok, .rx_err, .hit_valid, .hit_filter, .bus_receive_pin,
        .bus_transmit_pin_out, .bus_transmit_pin_oe, .engine_rx, .ack_enable,
        .error_flag_enable, .accept_all, .partial_copy, .tx_pending, .tx_index, .abort_req,
        .dest_valid, .dest_fifo, .dest_buffer, .irq);
    can_bus_model i_bus (.ref_clk, .reset_n, .tx_out(bus_transmit_pin_out),
        .tx_oe(bus_transmit_pin_oe), .dominant, .bit_tick, .rx_pin(bus_receive_pin));

    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_edges(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // One-cycle engine event on the selected input.
    task automatic ev(input int k, input logic [1:0] m);
        @(posedge ref_clk);
        hit_filter <= m;
        case (k)
            0: tx_ok <= m;
            1: tx_err <= m;
            2: tx_lost <= m;
            3: abort_ack <= m;
            4: remote_match <= m;
            5: rx_err <= m[0];
            6: hit_valid <= 1'b1;
            default: rx_ok <= m[0];
        endcase
        @(posedge ref_clk);
        {tx_ok, tx_err, tx_lost, abort_ack, remote_match, rx_err, hit_valid, rx_ok} <= '0;
        #1;
    endtask
    task automatic go_mode(input logic [2:0] code);
        wr(can_mode_pkg::ADDR_MODE, {5'h00, code, 8'h00});
        for (int i = 0; i < 40 && d[7:5] !== code; i++)
            rd(can_mode_pkg::ADDR_MODE, d);
        chk({13'h0000, d[7:5]}, {13'h0000, code});
        wait_edges(2);
    endtask

    // ****
    // Scenarios
    // ****
    task automatic t_reset();
        rd(can_mode_pkg::ADDR_FILT, d);
        chk(d, can_mode_pkg::FILT_RESET);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk(d, 16'h0000);
        rd(3'h7, d);
        chk(d, 16'h0000);
    endtask
    task automatic t_normal();
        chk({13'h0000, bus_transmit_pin_oe, ack_enable, error_flag_enable}, 16'h0007);
        @(posedge ref_clk);
        engine_tx <= 1'b0;
        wait_edges(2);
        chk({15'h0000, bus_transmit_pin_out}, 16'h0000);
        @(posedge ref_clk) engine_tx <= 1'b1;
        ev(5, 2'b01);
        rd(can_mode_pkg::ADDR_ERRCNT, d);
        chk(d, {8'h00, can_mode_pkg::RX_ERR_STEP});
    endtask
    task automatic t_idle_wait();
        @(posedge ref_clk) dominant <= 1'b1;
        wait_edges(5);
        wr(can_mode_pkg::ADDR_MODE, {5'h00, can_mode_pkg::REQ_LISTEN_ONLY, 8'h00});
        wait_edges(60);
        rd(can_mode_pkg::ADDR_MODE, d);
        chk(d, {5'h00, can_mode_pkg::REQ_LISTEN_ONLY, 8'h00});
        @(posedge ref_clk) dominant <= 1'b0;
    endtask
    task automatic t_listen_only();
        go_mode(can_mode_pkg::REQ_LISTEN_ONLY);
        chk({13'h0000, bus_transmit_pin_oe, ack_enable, error_flag_enable}, 16'h0000);
        ev(5, 2'b01);
        ev(7, 2'b01);
        rd(can_mode_pkg::ADDR_ERRCNT, d);
        chk(d, {8'h00, can_mode_pkg::RX_ERR_STEP});
    endtask
    task automatic t_listen_all();
        go_mode(can_mode_pkg::REQ_LISTEN_ALL);
        chk({14'h0000, bus_transmit_pin_oe, accept_all}, 16'h0003);
        ev(5, 2'b01);
        chk({15'h0000, partial_copy}, 16'h0001);
    endtask
    task automatic t_loopback();
        go_mode(can_mode_pkg::REQ_LOOPBACK);
        chk({15'h0000, bus_transmit_pin_oe}, 16'h0000);
        @(posedge ref_clk);
        engine_tx <= 1'b0;
        wait_edges(2);
        chk({15'h0000, engine_rx}, 16'h0000);
        @(posedge ref_clk) engine_tx <= 1'b1;
        // An unsupported code is held as a request but never entered.
        wr(can_mode_pkg::ADDR_MODE, 16'h0100);
        wait_edges(60);
        rd(can_mode_pkg::ADDR_MODE, d);
        chk(d, {5'h00, 3'h1, can_mode_pkg::REQ_LOOPBACK, 5'h00});
    endtask
    task automatic t_filter();
        logic [3:0] f;
        wr(can_mode_pkg::ADDR_FILT, 16'hf521);
        rd(can_mode_pkg::ADDR_FILT, d);
        chk(d, 16'hf521);
        for (int i = 0; i < 4; i++)
        begin
            f = d[4 * i +: 4];
            ev(6, i[1:0]);
            chk({14'h0000, dest_valid, dest_fifo}, {15'h0001, f == 4'hf});
            if (f != 4'hf)
                chk({12'h000, dest_buffer}, {12'h000, f});
        end
    endtask
    task automatic t_txbuf();
        wr(can_mode_pkg::ADDR_IMASK, 16'h0002);
        wr(can_mode_pkg::ADDR_TXCTL, 16'h0088);
        wait_edges(2);
        chk({14'h0000, tx_pending, tx_index}, 16'h0002);
        ev(1, 2'b01);
        ev(2, 2'b01);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk(d, 16'h00b8);
        ev(0, 2'b01);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk(d, 16'h0080);
        chk({15'h0000, irq}, 16'h0001);
        wr(can_mode_pkg::ADDR_IMASK, 16'h0000);
        wait_edges(2);
        chk({15'h0000, irq}, 16'h0000);
        wr(can_mode_pkg::ADDR_IMASK, 16'h0002);
        wait_edges(2);
        chk({15'h0000, irq}, 16'h0001);
        wr(can_mode_pkg::ADDR_ISTAT, 16'h0002);
        wait_edges(2);
        chk({15'h0000, irq}, 16'h0000);
    endtask
    task automatic t_prio_abort_remote();
        wr(can_mode_pkg::ADDR_TXCTL, 16'h888b);
        wait_edges(2);
        chk({14'h0000, tx_pending, tx_index}, 16'h0002);
        wr(can_mode_pkg::ADDR_TXCTL, 16'h8a89);
        wait_edges(2);
        chk({15'h0000, tx_index}, 16'h0001);
        ev(0, 2'b11);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk(d, 16'h8281);
        wr(can_mode_pkg::ADDR_TXCTL, 16'h0089);
        wr(can_mode_pkg::ADDR_TXCTL, 16'h0081);
        wait_edges(1);
        chk({14'h0000, abort_req}, 16'h0001);
        ev(3, 2'b01);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk(d, 16'h00c1);
        wr(can_mode_pkg::ADDR_TXCTL, 16'h8084);
        ev(4, 2'b11);
        rd(can_mode_pkg::ADDR_TXCTL, d);
        chk({14'h0000, d[11], d[3]}, 16'h0001);
    endtask

    // ****
    // Clock, timeout and verdict
    // ****
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        {reset_n, reg_wr, reg_rd, rx_ok, rx_err, hit_valid, dominant} = '0;
        {reg_addr, reg_wdata, tx_ok, tx_err, tx_lost, abort_ack, remote_match, hit_filter} = '0;
        engine_tx = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset_n <= 1'b1;
        wait_edges(2);
        t_reset();
        t_normal();
        t_idle_wait();
        t_listen_only();
        t_listen_all();
        t_loopback();
        t_filter();
        t_txbuf();
        t_prio_abort_remote();
        close_out();
    end
endmodule // can_modes_tx_buffer_control_tb_top
